// >>> hdl/pmc_clock_state_ctrl.sv
// Summary of operation
// [RL1] Master role drives master clock out, shift clock 64x, frame clock at Fs.
// [RL2] Slave role takes clocks from outside; master role makes them itself.
// [RL3] Outside source keeps frame and shift clocks synchronous to master clock.
// [RL4] In slave role the master clock output is held low.
// [RL5] Quad speed only in slave role, master clock at 128 times Fs.
// [RL6] Normal speed master clock is 8.192, 11.2896 or 12.288 MHz.
// [RL7] Double-rate select doubles Fs; master clock 22.5792 or 24.576 MHz.
// [RL8] 32 kHz sampling only at normal speed with double-rate low.
// [RL9] Quad speed detected when double-rate low and master clock is 128 Fs.
// [RL10] Only one clock source used; unused clock input tied low.
// [RL11] Shift and frame pins are outputs in master role, inputs in slave.
// [RL12] PLL loss of lock drives both valid indicators low.
// [RL13] Interpolation ratio eight normal, four double, two quad.
// [RL14] Any format select change in operation starts a reset sequence.
// [RL15] Power up: valid low, hard mute; PWM once initialization completes.
// [RL16] Controller asserts reset whenever it toggles role or double-rate select.
// [RL17] Reset is asynchronous; while low, hard mute and valid low.
// [RL18] Reset rising edge with power-down high starts initialization.
// [RL19] Power-down low shuts down PLL and oscillator asynchronously.
// [RL20] Reset and power-down both low: total power-down with hard mute.
// [RL21] Controller keeps clocks running until power-down has gone low.
// [RL22] Mute low gives 50% duty on both sides; high passes audio.
// [RL23] Missing clocks or phase errors: valid low, hard mute, then reinitialize; a stopped frame clock in slave role is not detected.
// [RL24] Valid raised only after initialization and PLL lock on valid clocks.
`timescale 1ns/1ps
`default_nettype none
module pmc_clock_state_ctrl (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Static control pins
  input wire logic power_down_n_i,
  input wire logic master_role_i,
  input wire logic double_rate_select_i,
  input wire logic mute_n_i,
  input wire logic format_select_bit0_i,
  input wire logic format_select_bit1_i,
  input wire logic format_select_bit2_i,
  input wire logic pll_locked_i,
  // Clock inputs
  input wire logic mclk_in_i,
  input wire logic crystal_input_i,
  // Two-way serial clocks
  input wire logic shift_clk_i,
  output logic shift_clk_o,
  output logic shift_clk_oe_o,
  input wire logic frame_clk_i,
  output logic frame_clk_o,
  output logic frame_clk_oe_o,
  // Audio side from modulator
  input wire logic [3:0] audio_p_i,
  // Outputs
  output logic mclk_out_o,
  output logic pll_enable_o,
  output logic osc_enable_o,
  output logic [3:0] pwm_p_o,
  output logic [3:0] pwm_m_o,
  output logic valid_left_o,
  output logic valid_right_o,
  output logic quad_speed_o,
  output logic [3:0] upsample_o
);
  typedef enum logic [3:0] {
    ST_RESET = 4'h1,
    ST_INIT = 4'h2,
    ST_RUN = 4'h4,
    ST_FAULT = 4'h8
  } pmc_state_t;

  typedef struct packed {
    pmc_state_t state;
    logic [pmc_pkg::CNT_W-1:0] init_cnt;
    logic [pmc_pkg::CNT_W-1:0] loss_cnt;
    logic [9:0] mclk_per_frame;
    logic [9:0] mclk_cnt;
    logic quad;
    logic rate_ok;
    logic primed;
    logic [6:0] shift_cnt;
    logic [2:0] fmt_seen;
    logic [7:0] div_cnt;
    logic shift_clk;
    logic frame_clk;
    logic mclk_out;
    logic [3:0] pwm_cnt;
    logic pwm_phase;
    logic [3:0] pwm_p;
    logic [3:0] pwm_m;
    logic valid;
    logic oe;
    logic pll_en;
    logic [3:0] ups;
  } pmc_ctrl_t;

  pmc_ctrl_t st_r;
  pmc_ctrl_t st_nxt;

  logic mclk_lvl, mclk_rise, frame_rise, pdn_lvl, mute_lvl, shift_rise;
  logic [2:0] fmt_lvl;
  logic lock_lvl;

  // Only one source is live; the other is tied low, so OR selects it
  pmc_sync_edge u_mclk (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .async_i(mclk_in_i | crystal_input_i), // RL10
    .level_o(mclk_lvl),
    .rise_o(mclk_rise)
  );
  pmc_sync_edge u_frame (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .async_i(master_role_i ? st_r.frame_clk : frame_clk_i),
    .level_o(),
    .rise_o(frame_rise)
  );
  pmc_sync_edge u_shift (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .async_i(master_role_i ? st_r.shift_clk : shift_clk_i),
    .level_o(),
    .rise_o(shift_rise)
  );
  // Mute is a loose pin like the others, so it is synchronised too
  pmc_sync_edge u_mute (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .async_i(mute_n_i),
    .level_o(mute_lvl),
    .rise_o()
  );
  pmc_sync_edge u_pdn (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .async_i(power_down_n_i),
    .level_o(pdn_lvl),
    .rise_o()
  );
  pmc_sync_edge u_lock (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .async_i(pll_locked_i),
    .level_o(lock_lvl),
    .rise_o()
  );
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_fmt
      pmc_sync_edge u_fmt (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .async_i(gi == 0 ? format_select_bit0_i :
                 gi == 1 ? format_select_bit1_i : format_select_bit2_i),
        .level_o(fmt_lvl[gi]),
        .rise_o()
      );
    end
  endgenerate

  function automatic logic in_band(input logic [9:0] v, input logic [9:0] lo,
                                   input logic [9:0] hi);
    in_band = (v >= lo) && (v <= hi);
  endfunction

  function automatic logic [3:0] ups_for(input logic quad, input logic dbl);
    if (quad) begin
      ups_for = pmc_pkg::UPS_QUAD;
    end else if (dbl) begin
      ups_for = pmc_pkg::UPS_DOUBLE;
    end else begin
      ups_for = pmc_pkg::UPS_NORMAL;
    end
  endfunction

  logic clocks_ok;
  assign clocks_ok = lock_lvl && st_r.rate_ok && (st_r.loss_cnt != '0);

  always_comb begin
    st_nxt = st_r;
    // Measure master clocks per frame to classify speed
    if (mclk_rise) begin
      st_nxt.mclk_cnt = st_r.mclk_cnt + 10'h001;
    end
    if (shift_rise) begin
      st_nxt.shift_cnt = st_r.shift_cnt + 7'h01;
    end
    if (frame_rise) begin
      st_nxt.mclk_per_frame = st_r.mclk_cnt;
      st_nxt.mclk_cnt = '0;
      st_nxt.shift_cnt = '0;
      st_nxt.primed = 1'b1;
    end
    // The first frame after reset or a clock stop is partial, so it only primes the counts
    if (frame_rise && st_r.primed) begin
      st_nxt.quad = !double_rate_select_i && !master_role_i &&
                    in_band(st_r.mclk_cnt, pmc_pkg::QUAD_LO, pmc_pkg::QUAD_HI); // RL9 RL5
      st_nxt.rate_ok = in_band(st_r.mclk_cnt, pmc_pkg::NORM_LO, pmc_pkg::NORM_HI) ||
                       st_nxt.quad;
      // A frame without a whole frame of shift clocks means the phases slipped
      if (st_r.shift_cnt != 7'(pmc_pkg::SHIFT_RATIO)) begin
        st_nxt.rate_ok = 1'b0; // RL23
      end
    end
    st_nxt.ups = ups_for(st_r.quad, double_rate_select_i); // RL13 RL8 RL7
    // Missing clock watchdog
    if (mclk_rise) begin
      st_nxt.loss_cnt = pmc_pkg::CNT_W'(pmc_pkg::CLK_LOSS_CYCLES);
    end else if (st_r.loss_cnt != '0) begin
      st_nxt.loss_cnt = st_r.loss_cnt - 1'b1;
    end else begin
      // A restarted clock may run at another rate; measure it afresh
      st_nxt.primed = 1'b0;
      st_nxt.rate_ok = 1'b0; // RL23
    end
    // Master role divider from the master clock
    st_nxt.mclk_out = master_role_i && pdn_lvl && mclk_lvl; // RL1 RL4
    if (mclk_rise) begin
      st_nxt.div_cnt = st_r.div_cnt + 8'h01;
      if (st_r.div_cnt[0] == 1'(pmc_pkg::SHIFT_HALF - 8'h01)) begin
        st_nxt.shift_clk = ~st_r.shift_clk; // RL1
      end
      if (st_r.div_cnt == pmc_pkg::FRAME_HALF - 8'h01 || st_r.div_cnt == 8'hff) begin
        st_nxt.frame_clk = ~st_r.frame_clk; // RL1
      end
    end
    st_nxt.oe = master_role_i; // RL11 RL2
    // Quiet-mute square wave
    st_nxt.pwm_cnt = st_r.pwm_cnt + 4'h1;
    if (st_r.pwm_cnt == pmc_pkg::PWM_HALF - 4'h1) begin
      st_nxt.pwm_cnt = '0;
      st_nxt.pwm_phase = ~st_r.pwm_phase;
    end
    st_nxt.pll_en = pdn_lvl;
    st_nxt.fmt_seen = fmt_lvl;
    case (st_r.state)
      ST_RESET: begin
        if (pdn_lvl) begin
          st_nxt.state = ST_INIT; // RL18
          st_nxt.init_cnt = pmc_pkg::CNT_W'(pmc_pkg::INIT_CYCLES);
        end
      end
      ST_INIT: begin
        if (!pdn_lvl) begin
          st_nxt.state = ST_RESET;
        end else if (st_r.init_cnt != '0) begin
          st_nxt.init_cnt = st_r.init_cnt - 1'b1;
        end else if (clocks_ok) begin
          st_nxt.state = ST_RUN; // RL24 RL15
        end
      end
      ST_RUN: begin
        if (!pdn_lvl) begin
          st_nxt.state = ST_RESET;
        end else if (fmt_lvl != st_r.fmt_seen) begin
          st_nxt.state = ST_INIT; // RL14
          st_nxt.init_cnt = pmc_pkg::CNT_W'(pmc_pkg::INIT_CYCLES);
        end else if (!clocks_ok) begin
          st_nxt.state = ST_FAULT; // RL12 RL23
        end
      end
      ST_FAULT: begin
        if (!pdn_lvl) begin
          st_nxt.state = ST_RESET;
        end else if (clocks_ok) begin
          st_nxt.state = ST_INIT; // RL23
          st_nxt.init_cnt = pmc_pkg::CNT_W'(pmc_pkg::INIT_CYCLES);
        end
      end
      default: begin
        st_nxt.state = ST_RESET;
      end
    endcase
    // Output stage: hard mute unless running
    st_nxt.valid = (st_nxt.state == ST_RUN);
    if (st_nxt.state != ST_RUN) begin
      st_nxt.pwm_p = 4'h0; // RL15 RL17 RL20
      st_nxt.pwm_m = 4'hf;
    end else if (!mute_lvl) begin
      st_nxt.pwm_p = {4{st_r.pwm_phase}}; // RL22
      st_nxt.pwm_m = {4{~st_r.pwm_phase}};
    end else begin
      st_nxt.pwm_p = audio_p_i;
      st_nxt.pwm_m = ~audio_p_i;
    end
  end

  // Reset acts without the clock; power-down goes through the clocked state; outputs land in hard mute
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= '{state: ST_RESET, pwm_m: 4'hf, ups: pmc_pkg::UPS_NORMAL, default: '0}; // RL17
    end else begin
      st_r <= st_nxt;
    end
  end

  // Power-down gates PLL and oscillator with no clock involved
  assign pll_enable_o = st_r.pll_en & power_down_n_i; // RL19
  assign osc_enable_o = st_r.pll_en & power_down_n_i;
  assign mclk_out_o = st_r.mclk_out;
  assign shift_clk_o = st_r.shift_clk;
  assign frame_clk_o = st_r.frame_clk;
  assign shift_clk_oe_o = st_r.oe;
  assign frame_clk_oe_o = st_r.oe;
  assign pwm_p_o = st_r.pwm_p;
  assign pwm_m_o = st_r.pwm_m;
  assign valid_left_o = st_r.valid;
  assign valid_right_o = st_r.valid;
  assign quad_speed_o = st_r.quad;
  assign upsample_o = st_r.ups;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  AST_SLAVE_MCLK_LOW: assert property (!master_role_i |=> !mclk_out_o) // RL4
    else $error("master clock out not low in slave role");
  AST_OE_ROLE: assert property ($past(rst_b_i) |-> shift_clk_oe_o == $past(master_role_i)) // RL11
    else $error("serial clock direction wrong");
  AST_HARD_MUTE: assert property (!valid_left_o |-> pwm_p_o == 4'h0 && pwm_m_o == 4'hf) // RL17
    else $error("outputs not hard muted while invalid");
  AST_VALID_PAIR: assert property (valid_left_o == valid_right_o) // RL12
    else $error("valid indicators differ");
  AST_LOCK_LOSS: assert property (!lock_lvl |=> ##1 !valid_left_o) // RL12
    else $error("valid high after lock loss");
  AST_FMT_CHANGE: assert property (valid_left_o && fmt_lvl != st_r.fmt_seen |=> !valid_left_o) // RL14
    else $error("format change did not restart");
  AST_PDN: assert property (!pdn_lvl |=> ##1 !valid_left_o) // RL20
    else $error("valid high in power down");
  AST_QUIET: assert property (valid_left_o && $past(!mute_lvl) |->
    pwm_p_o == {4{$past(st_r.pwm_phase)}} && pwm_m_o == ~pwm_p_o) // RL22
    else $error("quiet mute not complementary");
  AST_UPS: assert property (!st_r.quad && !double_rate_select_i |=> upsample_o == 4'h8) // RL13
    else $error("normal speed ratio wrong");
  AST_RISE: assert property ($rose(valid_left_o) |-> $past(st_r.state) == ST_INIT) // RL24
    else $error("valid raised without initialization");
  COV_RUN: cover property ($rose(valid_left_o));
  COV_MUTE: cover property (valid_left_o && !mute_n_i);
  COV_QUAD: cover property ($rose(quad_speed_o));
  COV_FAULT: cover property (st_r.state == ST_FAULT);
endmodule
`default_nettype wire

// >>> shared/pmc_pkg.sv
package pmc_pkg;
  // Clock of the block, in MHz
  localparam int CLK_MHZ = 100;
  // Initialization time after reset release, in microseconds
  localparam int INIT_TIME_US = 20;
  localparam int INIT_CYCLES = INIT_TIME_US * CLK_MHZ;
  // Link clock absent if no edge for this long, in microseconds
  localparam int CLK_LOSS_US = 2;
  localparam int CLK_LOSS_CYCLES = CLK_LOSS_US * CLK_MHZ;
  // Ratio figures
  localparam int MCLK_OUT_RATIO = 256;
  localparam int SHIFT_RATIO = 64;
  localparam int QUAD_MCLK_RATIO = 128;
  // Divider halves, counted in master clock edges
  localparam logic [7:0] SHIFT_HALF = 8'(MCLK_OUT_RATIO / SHIFT_RATIO / 2);
  localparam logic [7:0] FRAME_HALF = 8'(MCLK_OUT_RATIO / 2);
  // Tolerance when classifying master clocks per frame
  localparam logic [9:0] QUAD_LO = 10'h07c;
  localparam logic [9:0] QUAD_HI = 10'h084;
  localparam logic [9:0] NORM_LO = 10'h0fc;
  localparam logic [9:0] NORM_HI = 10'h104;
  // Interpolation factors
  localparam logic [3:0] UPS_NORMAL = 4'h8;
  localparam logic [3:0] UPS_DOUBLE = 4'h4;
  localparam logic [3:0] UPS_QUAD = 4'h2;
  // Quiet-mute PWM half period in block clocks
  localparam logic [3:0] PWM_HALF = 4'h8;
  localparam int CNT_W = 16;
endpackage

// >>> hdl/pmc_sync_edge.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser with rising-edge detect on the second stage
module pmc_sync_edge (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic async_i,
  output logic level_o,
  output logic rise_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } pmc_sync_t;
  pmc_sync_t st_r;
  pmc_sync_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = async_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_o = st_r.s2;
  assign rise_o = st_r.s2 & ~st_r.s3;
endmodule
`default_nettype wire

// >>> dv/pmc_audio_src.sv
`timescale 1ns/1ps
`default_nettype none
module pmc_audio_src (
  // Control from the bench
  input wire logic run_i,
  input wire logic quad_i,
  // Clocks towards the block
  output logic mclk_o,
  output logic sclk_o,
  output logic lrclk_o
);
  logic [7:0] div_r = 8'h00;
  initial mclk_o = 1'b0;
  // Scaled to 12.5 MHz, since the block samples this clock with its own
  always begin
    #40;
    mclk_o = run_i ? ~mclk_o : 1'b0;
  end
  always @(posedge mclk_o) div_r <= div_r + 8'h01;
  // Cut from the master clock, so they stay locked to it
  assign sclk_o = quad_i ? div_r[0] : div_r[1];
  assign lrclk_o = quad_i ? div_r[6] : div_r[7];
endmodule
`default_nettype wire

// >>> dv/pmc_clock_state_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pmc_clock_state_ctrl_tb_top;
  typedef struct packed {logic role; logic dbl; logic quad; logic [3:0] up; logic qd;} pmc_row_t;
  localparam pmc_row_t ROWS [4] = '{'{1'b0, 1'b0, 1'b0, 4'h8, 1'b0}, '{1'b0, 1'b1, 1'b0, 4'h4, 1'b0},
    '{1'b0, 1'b0, 1'b1, 4'h2, 1'b1}, '{1'b1, 1'b0, 1'b0, 4'h8, 1'b0}};
  logic clock_i = 1'b0;
  logic rst_b = 1'b0;
  logic power_down_n = 1'b1;
  logic role = 1'b0;
  logic dbl = 1'b0;
  logic mute_n = 1'b1;
  logic [2:0] fmt = 3'h0;
  logic lock = 1'b1;
  logic [3:0] audio = 4'h0;
  logic run = 1'b1;
  logic quad = 1'b0;
  logic p_mclk, p_sclk, p_lrclk, sclk_o, sclk_oe, lrclk_o, lrclk_oe, mclk_out, pll_en, osc_en;
  logic vl, vr, qs;
  logic [3:0] pwm_p, pwm_m, ups;
  wire logic sclk_w = sclk_oe ? sclk_o : p_sclk;
  wire logic lrclk_w = lrclk_oe ? lrclk_o : p_lrclk;
  int bad_count = 0;
  int num_checks = 0;
  int n;
  int m;
  always #5 clock_i = ~clock_i;
  pmc_audio_src src_u (.run_i(run), .quad_i(quad), .mclk_o(p_mclk), .sclk_o(p_sclk),
    .lrclk_o(p_lrclk));
  // Only one clock source is live; the other input is tied low
  pmc_clock_state_ctrl dut_u (.clock_i(clock_i), .rst_b_i(rst_b), .power_down_n_i(power_down_n),
    .master_role_i(role), .double_rate_select_i(dbl), .mute_n_i(mute_n),
    .format_select_bit0_i(fmt[0]), .format_select_bit1_i(fmt[1]), .format_select_bit2_i(fmt[2]),
    .pll_locked_i(lock), .mclk_in_i(role ? 1'b0 : p_mclk), .crystal_input_i(role & p_mclk),
    .shift_clk_i(sclk_w), .shift_clk_o(sclk_o), .shift_clk_oe_o(sclk_oe), .frame_clk_i(lrclk_w),
    .frame_clk_o(lrclk_o), .frame_clk_oe_o(lrclk_oe), .audio_p_i(audio), .mclk_out_o(mclk_out),
    .pll_enable_o(pll_en), .osc_enable_o(osc_en), .pwm_p_o(pwm_p), .pwm_m_o(pwm_m),
    .valid_left_o(vl), .valid_right_o(vr), .quad_speed_o(qs), .upsample_o(ups));
  task automatic stop_test;
    if (bad_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask
  task automatic chk_nib(input logic [3:0] got, input logic [3:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Role and rate only change while reset is held
  task automatic do_reset(input logic r, input logic d, input logic q);
    @(posedge clock_i);
    rst_b <= 1'b0;
    role <= r;
    dbl <= d;
    quad <= q;
    repeat (16) @(posedge clock_i);
    rst_b <= 1'b1;
  endtask
  task automatic wait_valid(input logic exp, input int lim);
    n = 0;
    while (vl !== exp && n < lim) begin
      @(negedge clock_i);
      n++;
    end
  endtask
  // Block clocks between two rising edges of the chosen output
  task automatic period(input logic fr, output int cnt);
    logic prev;
    cnt = 0;
    prev = 1'b1;
    while (!(prev === 1'b0 && (fr ? lrclk_o : sclk_o) === 1'b1) && cnt < 5000) begin
      prev = fr ? lrclk_o : sclk_o;
      @(negedge clock_i);
      cnt++;
    end
    cnt = 0;
    prev = 1'b1;
    while (!(prev === 1'b0 && (fr ? lrclk_o : sclk_o) === 1'b1) && cnt < 5000) begin
      prev = fr ? lrclk_o : sclk_o;
      @(negedge clock_i);
      cnt++;
    end
  endtask
  initial begin
    #800us;
    bad_count++;
    stop_test();
  end
  initial begin
    repeat (8) @(negedge clock_i);
    chk_nib(pwm_p, 4'h0, "reset p");
    chk_nib(pwm_m, 4'hf, "reset m");
    chk_bit(vl, 1'b0, "reset valid");
    chk_bit(mclk_out, 1'b0, "reset mclk out");
    repeat (8) @(posedge clock_i);
    rst_b <= 1'b1;
    repeat (1000) @(negedge clock_i);
    chk_bit(vl, 1'b0, "valid early");
    wait_valid(1'b1, 8000);
    chk_bit(vl, 1'b1, "valid after init");
    foreach (ROWS[i]) begin
      do_reset(ROWS[i].role, ROWS[i].dbl, ROWS[i].quad);
      wait_valid(1'b1, 8000);
      chk_bit(vr, 1'b1, "valid right");
      chk_nib(ups, ROWS[i].up, "upsample");
      chk_bit(qs, ROWS[i].qd, "quad detect");
      chk_bit(sclk_oe, ROWS[i].role, "shift dir");
      chk_bit(lrclk_oe, ROWS[i].role, "frame dir");
      n = 0;
      repeat (200) begin
        @(negedge clock_i);
        n += int'(mclk_out);
      end
      chk_bit(n > 20, ROWS[i].role, "mclk out activity");
      if (ROWS[i].role) begin
        period(1'b0, n);
        chk_bit(n >= 28 && n <= 36, 1'b1, "shift period");
        period(1'b1, n);
        chk_bit(n >= 2032 && n <= 2064, 1'b1, "frame period");
      end
    end
    do_reset(1'b0, 1'b0, 1'b0);
    wait_valid(1'b1, 8000);
    foreach (ROWS[i]) begin
      @(posedge clock_i);
      audio <= {ROWS[i].up[1:0], ~ROWS[i].up[3:2]};
      repeat (4) @(negedge clock_i);
      chk_nib(pwm_p, {ROWS[i].up[1:0], ~ROWS[i].up[3:2]}, "audio pass");
      chk_nib(pwm_m, ~{ROWS[i].up[1:0], ~ROWS[i].up[3:2]}, "audio pass m");
    end
    @(posedge clock_i);
    mute_n <= 1'b0;
    repeat (20) @(negedge clock_i);
    n = 0;
    m = 0;
    repeat (32) begin
      @(negedge clock_i);
      n += int'(pwm_p[0]);
      m += int'(pwm_m[3]);
    end
    chk_bit(n == 16, 1'b1, "quiet duty p");
    chk_bit(m == 16, 1'b1, "quiet duty m");
    @(posedge clock_i);
    mute_n <= 1'b1;
    fmt <= 3'h5;
    repeat (10) @(negedge clock_i);
    chk_bit(vl, 1'b0, "format change");
    wait_valid(1'b1, 8000);
    @(posedge clock_i);
    lock <= 1'b0;
    repeat (10) @(negedge clock_i);
    chk_bit(vl, 1'b0, "lock lost");
    @(posedge clock_i);
    lock <= 1'b1;
    wait_valid(1'b1, 8000);
    chk_bit(vl, 1'b1, "relock");
    @(posedge clock_i);
    run <= 1'b0;
    wait_valid(1'b0, 1000);
    chk_bit(vl, 1'b0, "clock loss");
    chk_nib(pwm_p, 4'h0, "loss mute");
    @(posedge clock_i);
    run <= 1'b1;
    wait_valid(1'b1, 8000);
    chk_bit(vl, 1'b1, "recovery");
    @(posedge clock_i);
    power_down_n <= 1'b0;
    #1;
    chk_bit(pll_en | osc_en, 1'b0, "power down");
    @(posedge clock_i);
    rst_b <= 1'b0;
    run <= 1'b0;
    repeat (4) @(negedge clock_i);
    chk_nib(pwm_m & ~pwm_p, 4'hf, "total power down");
    @(posedge clock_i);
    run <= 1'b1;
    power_down_n <= 1'b1;
    repeat (4) @(posedge clock_i);
    rst_b <= 1'b1;
    wait_valid(1'b1, 8000);
    chk_bit(vl, 1'b1, "power up");
    stop_test();
  end
endmodule
`default_nettype wire
